// ==== accessory_id_interrupt_regs.sv ====
// Accessory ID interrupt enable, status and latch registers.
`timescale 1ns/1ps
module accessory_id_interrupt_regs #(
   parameter int MEASURE_CYCLES = accessory_id_pkg::MEASURE_CYCLES
) (
   // Clock, reset and enable.
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // ULPI register access from the link state machine.
   input  wire logic       reg_ext,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_we,
   input  wire logic       reg_re,
   output logic      [7:0] reg_rdata,
   output logic            reg_rvalid,
   // RXCMD reporting.
   input  wire logic       rxcmd_sent,
   output logic            alt_int,
   // Analog side.
   input  wire logic       id_float_in,
   input  wire logic [2:0] sense_code
);

   // ***************************************************************
   // Address decode
   // ***************************************************************

   // Immediate accesses use six address bits, extended ones all eight.
   wire logic [7:0] eff_addr = reg_ext ? reg_addr
                             : (reg_addr & accessory_id_pkg::ADDR_IMM_MASK);

   // The enable register answers on its whole triple.
   wire logic en_hit = (eff_addr >= accessory_id_pkg::ADDR_EN_WRITE) &&
                       (eff_addr <= accessory_id_pkg::ADDR_EN_CLEAR);

   // The vendor measurement register sits in the vendor range.
   wire logic vnd_hit = (eff_addr >= accessory_id_pkg::ADDR_VND_WRITE) &&
                        (eff_addr <= accessory_id_pkg::ADDR_VND_CLEAR);

   // Status and latch are single read-only addresses.
   wire logic st_hit = (eff_addr == accessory_id_pkg::ADDR_STATUS);
   wire logic lt_hit = (eff_addr == accessory_id_pkg::ADDR_LATCH);

   // Access kinds for the two aliased triples.
   wire accessory_id_pkg::alias_op_e en_op =
      accessory_id_pkg::alias_of(eff_addr, accessory_id_pkg::ADDR_EN_WRITE);
   wire accessory_id_pkg::alias_op_e vnd_op =
      accessory_id_pkg::alias_of(eff_addr, accessory_id_pkg::ADDR_VND_WRITE);

   // Qualified strobes.
   wire logic en_write  = reg_we && en_hit;
   wire logic vnd_write = reg_we && vnd_hit;
   wire logic vnd_read  = reg_re && vnd_hit;
   wire logic lt_read   = reg_re && lt_hit;

   // ***************************************************************
   // Register state
   // ***************************************************************
   logic [7:0] irq_enable;    // Implemented enable bits only.
   logic [2:0] rid_code;      // Last resistance code.
   logic       measure_go;    // Start bit, cleared on completion.
   logic       vnd_rid_en;    // Vendor resistor done enable.
   logic       done_flag;     // Shared measurement done flag.
   logic       open_id_state; // Registered live ID floating state.
   logic       open_id_change_flag; // Latched enabled ID edge.
   logic       resistor_done_flag;  // Latched enabled done rise.
   logic       pending;       // Event waiting for the next RXCMD.

   measure_if meas ();        // Link to the measurement timer.

   // ***************************************************************
   // Enable register
   // ***************************************************************

   // Write, set and clear act through one function; stored bits are
   // limited to the implemented ones, so the rest read as zero.
   wire logic [7:0] next_irq_enable = en_write
      ? accessory_id_pkg::apply_alias(irq_enable, reg_wdata, en_op,
                                      accessory_id_pkg::EN_MASK)
      : irq_enable;

   wire logic open_id_rise_irq_en =
      irq_enable[accessory_id_pkg::EN_RISE];
   wire logic open_id_fall_irq_en =
      irq_enable[accessory_id_pkg::EN_FALL];

   // Either enable arms the resistor done event.
   wire logic resistor_done_irq_en =
      irq_enable[accessory_id_pkg::EN_RID] | vnd_rid_en;

   // ***************************************************************
   // Vendor measurement register
   // ***************************************************************

   // Current vendor byte as software sees it; bit 5 stays zero.
   wire logic [7:0] vnd_byte = {1'b0, vnd_rid_en, 1'b0, measure_go,
                                done_flag, rid_code};

   // Value after a write, set or clear; the done bit is not storable.
   wire logic [7:0] vnd_access =
      accessory_id_pkg::apply_alias(vnd_byte, reg_wdata, vnd_op,
                                    accessory_id_pkg::VND_MASK);

   // A start bit going from zero to one launches a measurement.
   wire logic start_req = vnd_write && !measure_go &&
                          vnd_access[accessory_id_pkg::V_GO];

   // Completion clears the start bit even when a write to other bits
   // of the register lands in the same cycle, so it never sticks.
   wire logic next_measure_go =
      (vnd_write ? vnd_access[accessory_id_pkg::V_GO] : measure_go)
      & ~meas.done;

   wire logic next_vnd_rid_en =
      vnd_write ? vnd_access[accessory_id_pkg::V_RID_EN] : vnd_rid_en;

   // A fresh result replaces any code written by software.
   wire logic [2:0] next_rid_code =
      meas.done ? meas.code
      : (vnd_write ? vnd_access[2:0] : rid_code);

   // ***************************************************************
   // Done flag
   // ***************************************************************

   // Only a read of the vendor register clears the flag; a status
   // read does not. A completion in the same cycle wins.
   wire logic next_done_flag =
      meas.done | (done_flag & ~vnd_read);

   // The flag's rising edge is the resistor event.
   wire logic done_rise = meas.done & ~done_flag;

   // ***************************************************************
   // Event detection
   // ***************************************************************

   // Edges of the ID floating state, taken against its last sample.
   wire logic id_goes_open   = id_float_in & ~open_id_state;
   wire logic id_leaves_open = ~id_float_in & open_id_state;

   // ID edge qualified by the matching enable.
   wire logic open_id_event =
      (id_goes_open & open_id_rise_irq_en) |
      (id_leaves_open & open_id_fall_irq_en);

   // Done rise qualified by the combined enable.
   wire logic resistor_event = done_rise & resistor_done_irq_en;

   // ***************************************************************
   // Latch and pending indication
   // ***************************************************************

   // A read clears the latch, but an event in that cycle survives.
   wire logic next_open_id_change_flag =
      open_id_event | (open_id_change_flag & ~lt_read);
   wire logic next_resistor_done_flag =
      resistor_event | (resistor_done_flag & ~lt_read);

   // The event is held until an RXCMD carries it; set wins.
   wire logic next_pending = open_id_event | resistor_event |
                             (pending & ~rxcmd_sent);

   // ***************************************************************
   // Read data
   // ***************************************************************

   // Status: live ID state, code and done; unused bits are zero. The
   // ID state is only meaningful with the pull-up switched on.
   wire logic [7:0] status_byte = {1'b0, done_flag, rid_code, 2'b00,
                                   open_id_state};

   // Latch: two implemented flags, everything else zero.
   wire logic [7:0] latch_byte = {4'h0, resistor_done_flag, 2'b00,
                                  open_id_change_flag};

   // Read multiplexer; unmapped addresses return zero.
   wire logic [7:0] next_rdata =
      en_hit  ? irq_enable :
      st_hit  ? status_byte :
      lt_hit  ? latch_byte :
      vnd_hit ? vnd_byte :
      accessory_id_pkg::BYTE_RESET;

   // ***************************************************************
   // Measurement timer
   // ***************************************************************
   id_resistor_meter #(
      .MEASURE_CYCLES (MEASURE_CYCLES)
   ) u_meter (
      .clk        (clk),
      .rst        (rst),
      .ce         (ce),
      .meas       (meas.engine),
      .sense_code (sense_code)
   );

   // Start request registered into a one-cycle pulse.
   logic go_pulse;
   assign meas.go = go_pulse;

   // ***************************************************************
   // Registers
   // ***************************************************************

   // Software-visible control; everything resets to zero.
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_enable <= accessory_id_pkg::BYTE_RESET;
         rid_code   <= accessory_id_pkg::CODE_RESET;
         measure_go <= 1'b0;
         vnd_rid_en <= 1'b0;
         go_pulse   <= 1'b0;
      end else if (ce) begin
         irq_enable <= next_irq_enable;
         rid_code   <= next_rid_code;
         measure_go <= next_measure_go;
         vnd_rid_en <= next_vnd_rid_en;
         go_pulse   <= start_req;
      end
   end

   // Hardware-set flags and the ID state sample.
   always_ff @(posedge clk) begin
      if (rst) begin
         done_flag           <= 1'b0;
         open_id_state       <= 1'b0;
         open_id_change_flag <= 1'b0;
         resistor_done_flag  <= 1'b0;
         pending             <= 1'b0;
      end else if (ce) begin
         done_flag           <= next_done_flag;
         open_id_state       <= id_float_in;
         open_id_change_flag <= next_open_id_change_flag;
         resistor_done_flag  <= next_resistor_done_flag;
         pending             <= next_pending;
      end
   end

   // Read answer one cycle after the request, and the RXCMD flag.
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata  <= accessory_id_pkg::BYTE_RESET;
         reg_rvalid <= 1'b0;
         alt_int    <= 1'b0;
      end else if (ce) begin
         reg_rvalid <= reg_re;
         alt_int    <= next_pending;
         if (reg_re) begin
            reg_rdata <= next_rdata;
         end
      end
   end

endmodule

// ==== accessory_id_interrupt_regs_asserts.sv ====
// Checker for the accessory ID interrupt register block.
`timescale 1ns/1ps
module accessory_id_interrupt_regs_asserts #(
   parameter int MEASURE_CYCLES = accessory_id_pkg::MEASURE_CYCLES
) (
   // Clock, reset and enable.
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       ce,
   // Register access.
   input wire logic       reg_ext,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_we,
   input wire logic       reg_re,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   // Event reporting and analog side.
   input wire logic       rxcmd_sent,
   input wire logic       alt_int,
   input wire logic       id_float_in,
   input wire logic [2:0] sense_code
);
   logic rd_take; // A read is taken at this edge.
   logic st_rd;   // Immediate read of the status register.
   logic lt_rd;   // Immediate read of the latch register.
   logic en_rd;   // Immediate read of any enable alias.
   assign rd_take = ce && reg_re;
   assign st_rd = rd_take && !reg_ext && reg_addr[5:0] == 6'h20;
   assign lt_rd = rd_take && !reg_ext && reg_addr[5:0] == 6'h21;
   assign en_rd = rd_take && !reg_ext && reg_addr[5:0] >= 6'h1d
                  && reg_addr[5:0] <= 6'h1f;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // Two status reads, the first showing the done flag.
   sequence status_pair;
      st_rd ##1 (st_rd && reg_rdata[6]);
   endsequence
   // Two latch reads with the ID level quiet throughout.
   sequence latch_pair;
      (lt_rd && $stable(id_float_in)) ##1 (lt_rd && $stable(id_float_in));
   endsequence

   rvalid_pulse_a: assert property (rd_take |=> reg_rvalid)
      else $error("read gave no rvalid");
   rvalid_idle_a: assert property (ce && !reg_re |=> !reg_rvalid)
      else $error("rvalid without a read");
   reset_zero_a: assert property ($fell(rst) |->
      reg_rdata == 8'h00 && !reg_rvalid && !alt_int)
      else $error("outputs not zero after reset");
   status_resv_a: assert property (st_rd |=>
      reg_rdata[7] == 1'b0 && reg_rdata[2:1] == 2'b00)
      else $error("status reserved bits set");
   latch_resv_a: assert property (lt_rd |=>
      reg_rdata[7:4] == 4'h0 && reg_rdata[2:1] == 2'b00)
      else $error("latch reserved bits set");
   enable_resv_a: assert property (en_rd |=>
      (reg_rdata & 8'hdc) == 8'h00)
      else $error("enable unimplemented bits set");
   status_live_a: assert property (st_rd && $stable(id_float_in) |=>
      reg_rdata[0] == $past(id_float_in))
      else $error("status bit 0 not live ID level");
   unmapped_zero_a: assert property (
      rd_take && reg_ext && reg_addr >= 8'h40 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   alt_hold_a: assert property (alt_int && !rxcmd_sent |=> alt_int)
      else $error("alt_int dropped before RXCMD");
   latch_clear_a: assert property (latch_pair |=> !reg_rdata[0])
      else $error("latch not cleared by read");
   done_keep_a: assert property (status_pair |=> reg_rdata[6])
      else $error("status read cleared done");
endmodule

bind accessory_id_interrupt_regs accessory_id_interrupt_regs_asserts #(
   .MEASURE_CYCLES(MEASURE_CYCLES)
) u_chk (.clk(clk), .rst(rst), .ce(ce), .reg_ext(reg_ext),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
   .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .rxcmd_sent(rxcmd_sent), .alt_int(alt_int),
   .id_float_in(id_float_in), .sense_code(sense_code));

// ==== accessory_id_interrupt_regs_tb.sv ====
// Self-checking testbench for the accessory ID interrupt registers.
`timescale 1ns/1ps
module accessory_id_interrupt_regs_tb;
   localparam int MC = 8; // Shortened measurement length.
   logic       clk, rst, ce, reg_ext, reg_we, reg_re;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       reg_rvalid, rxcmd_sent, alt_int, id_float_in, x;
   logic [2:0] sense_code, code, prev;
   logic [7:0] e, r, expq[$];  // Expected read data, oldest first.
   int         ack_delay, i, k, mode, n_mismatch, checks_done;
   integer     seed = 32'h6d54;

   accessory_id_interrupt_regs #(.MEASURE_CYCLES(MC)) dut (
      .clk(clk), .rst(rst), .ce(ce), .reg_ext(reg_ext),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
      .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .rxcmd_sent(rxcmd_sent), .alt_int(alt_int),
      .id_float_in(id_float_in), .sense_code(sense_code));
   link_ctrl_model u_link (.clk(clk), .rst(rst), .alt_int(alt_int),
      .ack_delay(ack_delay), .rxcmd_sent(rxcmd_sent));

   // Compares one value and reports a difference at once.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One access; a read queues d as its expected data.
   task automatic acc(input logic w, input logic xt,
                      input logic [7:0] a, input logic [7:0] d);
      reg_we = w;
      reg_re = !w;
      reg_ext = xt;
      reg_addr = a;
      reg_wdata = d;
      if (!w) begin
         expq.push_back(d);
      end
      @(posedge clk);
      #1;
   endtask

   // Drops the strobes and lets n cycles pass.
   task automatic idle(input int n);
      reg_we = 1'b0;
      reg_re = 1'b0;
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   // Lets the link answer, then expects alt_int to be gone.
   task automatic ack_and_check();
      idle(1);
      ack_delay = 0;
      idle(4);
      chk(8'(alt_int), 8'h00);
      ack_delay = 1000;
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Clock of 25 ns period.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Each returned read is matched with the oldest queued note.
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (expq.size() == 0) begin
            n_mismatch++;
            $display("Error at %0t: read data with no request", $time);
         end else begin
            chk(reg_rdata, expq.pop_front());
         end
      end
   end

   // Cuts a hang short.
   initial begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end

   // Main sequence.
   initial begin
      {rst, ce, reg_ext, reg_we, reg_re, id_float_in} = 6'b110000;
      {reg_addr, reg_wdata, sense_code, prev} = '0;
      ack_delay = 1000;
      repeat (6) @(posedge clk);
      #1;
      rst = 1'b0;
      // The ID level is driven as if the pull-up were on.
      for (i = 0; i < 8; i++) begin
         acc(1'b0, 1'b0, (i < 5) ? 8'(29 + i) : 8'(49 + i), 8'h00);
      end
      idle(2);
      $display("Reset values test done");
      for (i = 0; i < 4; i++) begin
         e = 8'($random(seed));
         acc(1'b1, 1'b0, accessory_id_pkg::ADDR_EN_WRITE, e);
         e &= accessory_id_pkg::EN_MASK;
         for (k = 0; k < 3; k++) begin
            acc(1'b0, 1'b0, 8'(29 + k), e);
         end
         acc(1'b0, 1'b1, 8'h1e, e);
         acc(1'b0, 1'b0, 8'hdf, e);
         r = 8'($random(seed));
         acc(1'b1, 1'b0, 8'h1e, r);
         e |= r & accessory_id_pkg::EN_MASK;
         acc(1'b0, 1'b0, 8'h1d, e);
         r = 8'($random(seed));
         acc(1'b1, 1'b0, accessory_id_pkg::ADDR_EN_CLEAR, r);
         e &= ~r;
         acc(1'b0, 1'b0, 8'h1d, e);
      end
      acc(1'b1, 1'b0, 8'h20, 8'hff);
      acc(1'b1, 1'b0, 8'h21, 8'hff);
      acc(1'b1, 1'b1, 8'h45, 8'hff);
      acc(1'b0, 1'b0, 8'h20, 8'h00);
      acc(1'b0, 1'b0, 8'h21, 8'h00);
      acc(1'b0, 1'b1, 8'h45, 8'h00);
      idle(2);
      $display("Enable alias test done");
      for (i = 0; i < 4; i++) begin
         for (k = 0; k < 2; k++) begin
            acc(1'b1, 1'b0, 8'h1d, 8'h00);
            id_float_in = k[0];
            idle(2);
            acc(1'b1, 1'b0, 8'h1d, 8'(i));
            id_float_in = !k[0];
            idle(3);
            x = k[0] ? i[1] : i[0];
            chk(8'(alt_int), 8'(x));
            acc(1'b0, 1'b0, 8'h20, {7'h00, !k[0]});
            acc(1'b0, 1'b0, 8'h21, {7'h00, x});
            acc(1'b0, 1'b0, 8'h21, 8'h00);
            ack_and_check();
         end
      end
      $display("ID edge test done");
      for (k = 0; k < 7; k++) begin
         code = (k == 6) ? 3'h7 : 3'(k);
         mode = k % 3;
         sense_code = code;
         acc(1'b1, 1'b0, 8'h1d, (mode == 0) ? 8'h20 : 8'h00);
         acc(1'b1, 1'b0, 8'h38, 8'h40);
         acc(1'b1, 1'b0, 8'h37, (mode == 1) ? 8'h50 : 8'h10);
         acc(1'b0, 1'b0, 8'h20, {2'b00, prev, 3'b000});
         idle(MC + 6);
         chk(8'(alt_int), 8'(mode != 2));
         acc(1'b0, 1'b0, 8'h20, {2'b01, code, 3'b000});
         acc(1'b0, 1'b0, 8'h20, {2'b01, code, 3'b000});
         acc(1'b0, 1'b0, 8'h21, {4'h0, mode != 2, 3'b000});
         acc(1'b0, 1'b0, 8'h36, {1'b0, mode == 1, 3'b001, code});
         acc(1'b0, 1'b0, 8'h20, {2'b00, code, 3'b000});
         ack_and_check();
         prev = code;
      end
      $display("Measurement test done");
      idle(4);
      tally_and_finish();
   end
endmodule

// ==== accessory_id_pkg.sv ====
// Constants, types and helper functions shared by the accessory ID block.
package accessory_id_pkg;

   // ***************************************************************
   // Register addresses
   // ***************************************************************
   localparam logic [7:0] ADDR_EN_WRITE = 8'h1d; // Enable, direct write.
   localparam logic [7:0] ADDR_EN_CLEAR = 8'h1f; // Enable, bit clear.
   localparam logic [7:0] ADDR_STATUS   = 8'h20; // Live status.
   localparam logic [7:0] ADDR_LATCH    = 8'h21; // Latch, clear on read.
   localparam logic [7:0] ADDR_VND_WRITE = 8'h36; // Vendor, direct write.
   localparam logic [7:0] ADDR_VND_CLEAR = 8'h38; // Vendor, bit clear.
   localparam logic [7:0] ADDR_IMM_MASK = 8'h3f; // Immediate address field.

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int EN_RISE   = 0; // Open ID rise enable.
   localparam int EN_FALL   = 1; // Open ID fall enable.
   localparam int EN_RID    = 5; // Resistor done enable.
   localparam int V_DONE    = 3; // Vendor copy of the done flag.
   localparam int V_GO      = 4; // Measurement start.
   localparam int V_RID_EN  = 6; // Vendor resistor done enable.

   // ***************************************************************
   // Masks and reset values
   // ***************************************************************
   localparam logic [7:0] EN_MASK    = 8'h23; // Implemented enable bits.
   localparam logic [7:0] VND_MASK   = 8'h57; // Storable vendor bits.
   localparam logic [7:0] BYTE_RESET = 8'h00; // Register reset value.
   localparam logic [2:0] CODE_RESET = 3'h0;  // Resistor code reset.
   localparam logic [7:0] CODE_MASK  = 8'h07; // Resistor code field.

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int MEASURE_TIME_US = 282; // Duration of a measurement.
   localparam int CLK_FREQ_MHZ    = 40;  // Rate of clk.
   localparam int MEASURE_CYCLES  = MEASURE_TIME_US * CLK_FREQ_MHZ;
   localparam int MEASURE_CNT_W   = 14;  // Width of the cycle counter.

   // Kind of access made through an aliased register triple.
   typedef enum logic [1:0] {
      ALIAS_WRITE,
      ALIAS_SET,
      ALIAS_CLEAR
   } alias_op_e;

   // Selects the access kind from the address and the triple's base.
   function automatic alias_op_e alias_of(input logic [7:0] addr,
                                          input logic [7:0] base);
      alias_op_e op;
      op = ALIAS_CLEAR;
      if (addr == base) begin
         op = ALIAS_WRITE;
      end else if (addr == base + 8'h01) begin
         op = ALIAS_SET;
      end
      return op;
   endfunction

   // Applies a write, set or clear access and keeps only stored bits.
   function automatic logic [7:0] apply_alias(input logic [7:0] cur,
                                              input logic [7:0] wd,
                                              input alias_op_e  op,
                                              input logic [7:0] mask);
      logic [7:0] r;
      r = cur;
      unique case (op)
         ALIAS_WRITE: r = wd;
         ALIAS_SET:   r = cur | wd;
         ALIAS_CLEAR: r = cur & ~wd;
         default:     r = cur;
      endcase
      return r & mask;
   endfunction

endpackage

// ==== id_resistor_meter.sv ====
// Timer that runs one ID resistor measurement and returns its code.
`timescale 1ns/1ps
module id_resistor_meter #(
   parameter int MEASURE_CYCLES = accessory_id_pkg::MEASURE_CYCLES
) (
   // Clock, reset and enable.
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // Link to the register logic.
   measure_if.engine       meas,
   // Result of the analog comparator chain.
   input  wire logic [2:0] sense_code
);

   // ***************************************************************
   // State and counter
   // ***************************************************************
   typedef enum logic {IDLE, RUN} meter_state_e;

   localparam int W = accessory_id_pkg::MEASURE_CNT_W;
   localparam logic [W-1:0] LAST = W'(MEASURE_CYCLES - 1);
   localparam logic [W-1:0] ZERO = W'(0);
   localparam logic [W-1:0] ONE  = W'(1);

   meter_state_e   state;      // Idle or measuring.
   logic [W-1:0]   count;      // Cycles spent in the measurement.
   logic           done_q;     // Done pulse register.
   logic [2:0]     code_q;     // Captured result.

   // The last cycle of the measurement window.
   wire logic at_end = (state == RUN) && (count == LAST);

   assign meas.done = done_q;
   assign meas.code = code_q;

   // Counts the window; a start request while running is ignored.
   always_ff @(posedge clk) begin
      if (rst) begin
         state  <= IDLE;
         count  <= ZERO;
         done_q <= 1'b0;
         code_q <= accessory_id_pkg::CODE_RESET;
      end else if (ce) begin
         done_q <= at_end;
         unique case (state)
            IDLE: begin
               count <= ZERO;
               if (meas.go) begin
                  state <= RUN;
               end
            end
            RUN: begin
               count <= count + ONE;
               if (at_end) begin
                  // The result is sampled at the end of the window.
                  code_q <= sense_code;
                  state  <= IDLE;
               end
            end
         endcase
      end
   end

endmodule

// ==== link_ctrl_model.sv ====
// Link controller model that answers alt_int with an RXCMD.
`timescale 1ns/1ps
module link_ctrl_model (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst,
   // Event indication and reply pacing, in cycles.
   input  wire logic alt_int,
   input  var  int   ack_delay,
   // One-cycle pulse when an RXCMD with alt_int went out.
   output logic      rxcmd_sent
);
   int wait_cnt; // Cycles that alt_int has been pending.

   // A busy link sends its next RXCMD only after ack_delay cycles.
   always @(posedge clk) begin
      rxcmd_sent <= 1'b0;
      wait_cnt   <= 0;
      if (!rst && alt_int === 1'b1 && !rxcmd_sent) begin
         if (wait_cnt >= ack_delay) begin
            rxcmd_sent <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 1;
         end
      end
   end
endmodule

// ==== measure_if.sv ====
// Interface between the register logic and the resistor meter.
`timescale 1ns/1ps
interface measure_if;
   logic       go;   // One-cycle request to start a measurement.
   logic       done; // One-cycle pulse when a measurement ends.
   logic [2:0] code; // Resistance code, valid with done.

   modport ctrl   (output go, input done, input code);
   modport engine (input go, output done, output code);
endinterface
